// File: hw/blpd_params.svh
// Purpose: constants of the backlight pwm detect and fault slice
// Assumes: 100 MHz aclk
// Notes:   register offsets are indexes; byte address is four times
`ifndef BLPD_PARAMS_SVH
`define BLPD_PARAMS_SVH
// register indexes
`define BP_IX_CFG     6'h02
`define BP_IX_SMP     6'h03
`define BP_IX_BRT_LO  6'h04
`define BP_IX_BRT_HI  6'h05
`define BP_IX_PCTL    6'h09
`define BP_IX_EN      6'h0a
`define BP_IX_FLAGS   6'h10
// field positions
`define BP_F_OVP_HI   7
`define BP_F_OVP_LO   5
`define BP_F_MAP      4
`define BP_F_POL      3
`define BP_F_BFREQ    7
`define BP_F_RATE     2
`define BP_F_PWM_EN   6
`define BP_F_BACKLIGHT_ENABLE_BIT    0
`define BP_F_LATCH    1
`define BP_F_SINK2    3
`define BP_F_SINK1    4
`define BP_F_OCP      0
`define BP_F_OVPF     1
`define BP_F_TMO      2
// reset values
`define BP_RST_CFG    8'h00
`define BP_RST_SMP    8'h00
`define BP_RST_BRT    11'h000
// timing
`define BP_CLK_MHZ    100
`define BP_DIV_1M     (`BP_CLK_MHZ / 1)
`define BP_DIV_4M     (`BP_CLK_MHZ / 4)
`define BP_TMO_1M_MS  25
`define BP_TMO_4M_MS  3
`define BP_TMO_1M     15'(`BP_TMO_1M_MS * 1000 * 1)
`define BP_TMO_4M     15'(`BP_TMO_4M_MS * 1000 * 4)
`define BP_PER_1M     8'(`BP_CLK_MHZ / 1)
`define BP_PER_500K   8'(`BP_CLK_MHZ * 2)
`define BP_TON_MAX    8'd90
`define BP_WIN_US     128
`define BP_WIN_CYC    14'(`BP_WIN_US * `BP_CLK_MHZ)
`define BP_OCP_MIN    2'd2
`define BP_OCP_WINS   4'd8
`define BP_OVP_OCC    2'd3
`define BP_HR_LOW_MV  8'd40
`define BP_HR_BASE_MV 8'd100
// hysteresis steps per setting
`define BP_HYST0      11'd0
`define BP_HYST1      11'd1
`define BP_HYST2      11'd2
`define BP_HYST3      11'd4
// mapper: linear offset and slope, exponent scale
`define BP_LIN_OFS    20'd1549
`define BP_LIN_SLOPE  20'd500
`define BP_EXP_MUL    15'd9
`endif

// File: hw/blpd_pkg.sv
// Purpose: types of the backlight pwm detect and fault slice
// Assumes: nothing
// Notes:   constants live in blpd_params.svh
package blpd_pkg;
   typedef enum logic {DIV_IDLE, DIV_RUN} blpd_div_t;
   typedef logic [10:0] blpd_code_t;
endpackage

// File: hw/blpd_top.sv
// Purpose: pwm duty detector, mapper, boost control and faults
// Assumes: all inputs synchronous to aclk; axi4-lite register port
// Notes:   analog comparators and headroom values arrive as inputs
`timescale 1ns/10ps
`include "blpd_params.svh"
// Operation
// - map bit selects exponential or linear curve
// - period measured rising edge to rising edge
// - polarity bit inverts pwm input level
// - sample rate 1 or 4 MHz
// - timeout 25 ms or 3 ms
// - duty becomes 11-bit brightness code
// - four hysteresis settings in LSB steps
// - hysteresis only on direction reversal
// - stuck-low timeout with pwm enabled stops boost
// - boost switching 500 kHz or 1 MHz
// - regulate on smaller sink headroom
// - overvoltage threshold select field
// - overvoltage sets flag, resumes if unlatched
// - latched: three low-headroom hits shut backlight down
// - re-enable refused until flags read
// - current limit ends switch on-time
// - overcurrent flag clears on flags read
// - eight windows of two events flag
// - pwm mode multiplies code by duty
// - brightness commits on upper byte write
module blpd_top import blpd_pkg::*; (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write
   input  wire logic [7:0]  s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   output logic [1:0]       s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   // pwm pin and analog sense
   input  wire logic        pwm_pin,
   input  wire logic        ovp_cmp,
   input  wire logic        ocp_cmp,
   input  wire logic [7:0]  sink_one_hr,
   input  wire logic [7:0]  sink_two_hr,
   // driver controls
   output logic             boost_gate,
   output logic             boost_switch_freq_select,
   output logic [2:0]       ovp_thresh_sel,
   output logic [19:0]      current_code,
   output logic             sink_one_en,
   output logic             sink_two_en
);
   // register state
   logic [7:0]  cfg_q, smp_q;
   logic [2:0]  brt_lo_q;
   blpd_code_t  brt_q;
   logic        pwm_en_q, backlight_enable_bit_q, latch_q, s1_q, s2_q;
   logic        ocp_flag_q, ovp_flag_q, lock_q;
   logic        tmo_q;                         // pwm timeout status
   // bus state
   logic        aw_have_q, w_have_q;
   logic [7:0]  awaddr_q;
   logic [7:0]  wdata_q;
   logic        wstrb_q;
   logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0]  bresp_q, rresp_q;
   logic [31:0] rdata_q;

   logic       do_wr, rd_clr, ar_hs;
   logic [5:0] wr_ix, rd_ix;
   logic       wr_ok, rd_ok;
   logic       ovp_shut, ocp_set, ovp_set;

   assign do_wr = aw_have_q & w_have_q & ~bvalid_q;
   assign wr_ix = awaddr_q[7:2];
   assign rd_ix = s_araddr[7:2];
   assign ar_hs = s_arvalid & arready_q;
   assign rd_clr = ar_hs & rd_ok & (rd_ix == `BP_IX_FLAGS);

   // decode of mapped indexes
   function automatic logic mapped(input logic [5:0] ix);
      mapped = ix == `BP_IX_CFG || ix == `BP_IX_SMP ||
               ix == `BP_IX_BRT_LO || ix == `BP_IX_BRT_HI ||
               ix == `BP_IX_PCTL || ix == `BP_IX_EN ||
               ix == `BP_IX_FLAGS;
   endfunction
   assign wr_ok = mapped(wr_ix);
   assign rd_ok = mapped(rd_ix);

   // write channel: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 8'h00;
         wstrb_q   <= 1'b0;
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         bvalid_q  <= 1'b0;
         bresp_q   <= 2'h0;
      end else begin
         if (s_awvalid && awready_q) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= s_awaddr;
            awready_q <= 1'b0;
         end
         if (s_wvalid && wready_q) begin
            w_have_q <= 1'b1;
            wdata_q  <= s_wdata[7:0];
            wstrb_q  <= s_wstrb[0];
            wready_q <= 1'b0;
         end
         if (do_wr) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_ok ? 2'h0 : 2'h2;
         end
         if (bvalid_q && s_bready) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // read channel: one read at a time, answer one edge after taking
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0;
         rresp_q   <= 2'h0;
      end else begin
         if (ar_hs) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= rd_ok ? 2'h0 : 2'h2;
            unique case (rd_ix)
               `BP_IX_CFG:    rdata_q <= {24'h0, cfg_q};
               `BP_IX_SMP:    rdata_q <= {24'h0, smp_q};
               `BP_IX_BRT_LO: rdata_q <= {29'h0, brt_lo_q};
               `BP_IX_BRT_HI: rdata_q <= {24'h0, brt_q[10:3]};
               `BP_IX_PCTL:   rdata_q <= {25'h0, pwm_en_q, 6'h0};
               `BP_IX_EN:     rdata_q <= {27'h0, s1_q, s2_q,
                                          1'b0, latch_q, backlight_enable_bit_q};
               `BP_IX_FLAGS:  rdata_q <= {29'h0, tmo_q,
                                          ovp_flag_q, ocp_flag_q};
               default:       rdata_q <= 32'h0;
            endcase
         end
         if (rvalid_q && s_rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   // configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_q    <= `BP_RST_CFG;
         smp_q    <= `BP_RST_SMP;
         brt_lo_q <= 3'h0;
         brt_q    <= `BP_RST_BRT;
         pwm_en_q <= 1'b0;
         latch_q  <= 1'b0;
         s1_q     <= 1'b0;
         s2_q     <= 1'b0;
      end else if (do_wr && wstrb_q) begin
         unique case (wr_ix)
            `BP_IX_CFG:    cfg_q <= wdata_q;
            `BP_IX_SMP:    smp_q <= wdata_q & 8'h87;
            `BP_IX_BRT_LO: brt_lo_q <= wdata_q[2:0];
            `BP_IX_BRT_HI: brt_q <= {wdata_q, brt_lo_q};
            `BP_IX_PCTL:   pwm_en_q <= wdata_q[`BP_F_PWM_EN];
            `BP_IX_EN: begin
               latch_q <= wdata_q[`BP_F_LATCH];
               s1_q    <= wdata_q[`BP_F_SINK1];
               s2_q    <= wdata_q[`BP_F_SINK2];
            end
            default: ;
         endcase
      end
   end

   // backlight enable: overvoltage shutdown beats any write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         backlight_enable_bit_q <= 1'b0;
      end else if (ovp_shut) begin
         backlight_enable_bit_q <= 1'b0;
      end else if (do_wr && wstrb_q && wr_ix == `BP_IX_EN) begin
         // refused until flags are read after a shutdown
         backlight_enable_bit_q <= wdata_q[`BP_F_BACKLIGHT_ENABLE_BIT] & ~lock_q;
      end
   end

   // pwm sample tick: 1 MHz or 4 MHz
   logic [6:0] tdiv_q;
   logic       tick;
   logic       rate4;
   assign rate4 = smp_q[`BP_F_RATE];
   assign tick = tdiv_q == 7'(rate4 ? `BP_DIV_4M - 1 : `BP_DIV_1M - 1);
   always_ff @(posedge aclk) begin
      if (!aresetn) tdiv_q <= 7'h0;
      else tdiv_q <= tick ? 7'h0 : tdiv_q + 7'h1;
   end

   // sampled level, period counters and timeout
   logic        lvl_q, prev_q, rise;
   logic [14:0] tot_q, hi_q, to_q;
   logic [14:0] tmo_lim;
   assign tmo_lim = rate4 ? `BP_TMO_4M : `BP_TMO_1M;
   assign rise = lvl_q & ~prev_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lvl_q  <= 1'b0;
         prev_q <= 1'b0;
         tot_q  <= 15'h0;
         hi_q   <= 15'h0;
         to_q   <= 15'h0;
         tmo_q  <= 1'b0;
      end else if (tick) begin
         lvl_q  <= pwm_pin ^ cfg_q[`BP_F_POL];
         prev_q <= lvl_q;
         if (rise) begin
            // new period starts with this high sample
            tot_q <= 15'h1;
            hi_q  <= 15'h1;
            to_q  <= 15'h0;
            tmo_q <= 1'b0;
         end else begin
            if (tot_q != 15'h7fff) tot_q <= tot_q + 15'h1;
            if (hi_q != 15'h7fff) hi_q <= hi_q + {14'h0, lvl_q};
            if (to_q >= tmo_lim) tmo_q <= 1'b1;
            else to_q <= to_q + 15'h1;
         end
      end
   end

   // serial divider: 12 quotient bits of high/total
   blpd_div_t   dst_q;
   logic [15:0] rem_q;
   logic [14:0] den_q;
   logic [11:0] quo_q;
   logic [3:0]  dcnt_q;
   logic        dv_done_q;
   logic [15:0] rem2;
   assign rem2 = {rem_q[14:0], 1'b0};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dst_q     <= DIV_IDLE;
         rem_q     <= 16'h0;
         den_q     <= 15'h0;
         quo_q     <= 12'h0;
         dcnt_q    <= 4'h0;
         dv_done_q <= 1'b0;
      end else begin
         dv_done_q <= 1'b0;
         unique case (dst_q)
            DIV_IDLE: if (tick && rise && tot_q != 15'h0 && !tmo_q) begin
               // a period that timed out is not a period
               rem_q  <= {1'b0, hi_q};
               den_q  <= tot_q;
               quo_q  <= 12'h0;
               dcnt_q <= 4'd12;
               dst_q  <= DIV_RUN;
            end
            DIV_RUN: begin
               // 12 steps yields floor(high*2048/total)
               if (rem_q >= {1'b0, den_q}) begin
                  rem_q <= (rem_q - {1'b0, den_q}) << 1;
                  quo_q <= {quo_q[10:0], 1'b1};
               end else begin
                  rem_q <= rem2;
                  quo_q <= {quo_q[10:0], 1'b0};
               end
               dcnt_q <= dcnt_q - 4'h1;
               if (dcnt_q == 4'h1) begin
                  dst_q     <= DIV_IDLE;
                  dv_done_q <= 1'b1;
               end
            end
         endcase
      end
   end

   // new duty sample: divider result or stuck level after timeout
   blpd_code_t new_duty;
   logic       new_vld;
   always_comb begin
      new_vld  = dv_done_q | (tmo_q & tick);
      new_duty = 11'h0;
      if (dv_done_q) // clamp the full 2048 case
         new_duty = quo_q[11] ? 11'h7ff : quo_q[10:0];
      else if (tmo_q)
         new_duty = lvl_q ? 11'h7ff : 11'h000;
   end

   // hysteresis on direction reversal only
   blpd_code_t duty_q, hyst, dlt;
   logic       up_q, go_up;
   always_comb begin
      unique case (smp_q[1:0])
         2'd0: hyst = `BP_HYST0;
         2'd1: hyst = `BP_HYST1;
         2'd2: hyst = `BP_HYST2;
         2'd3: hyst = `BP_HYST3;
      endcase
      go_up = new_duty > duty_q;
      dlt   = go_up ? new_duty - duty_q : duty_q - new_duty;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         duty_q <= 11'h0;
         up_q   <= 1'b1;
      end else if (new_vld && new_duty != duty_q) begin
         if (go_up == up_q) begin
            duty_q <= new_duty;
         end else if (dlt > hyst) begin
            duty_q <= new_duty;
            up_q   <= go_up;
         end
      end
   end

   // brightness word, scaled by duty in pwm mode
   logic [21:0] prod;
   blpd_code_t  word;
   logic        active;
   assign prod = brt_q * duty_q;
   always_comb begin
      word = brt_q;
      if (pwm_en_q)
         word = (duty_q == 11'h7ff) ? brt_q : prod[21:11];
   end
   // stuck-low timeout gives zero word; boost stops too
   assign active = backlight_enable_bit_q & (s1_q | s2_q) & (word != 11'h0) &
                   ~(pwm_en_q & tmo_q & ~lvl_q);

   // mapper: exponential is piecewise 2^(n*9/2048)
   logic [14:0] ex;
   logic [19:0] map_v;
   always_comb begin
      ex = word * `BP_EXP_MUL;
      if (cfg_q[`BP_F_MAP])
         map_v = 20'({1'b1, ex[10:0]}) << ex[14:11];
      else
         map_v = `BP_LIN_OFS + `BP_LIN_SLOPE * 20'(word);
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) current_code <= 20'h0;
      else current_code <= active ? map_v : 20'h0;
   end

   // boost: regulate on lower enabled headroom
   logic [7:0] per_q, ton_q, per_lim, fb, tgt;
   logic       cut_q, ocp_prev_q, per_end;
   assign per_lim = smp_q[`BP_F_BFREQ] ? `BP_PER_1M
                                       : `BP_PER_500K;
   assign per_end = per_q == per_lim - 8'h1;
   always_comb begin
      fb = 8'hff;
      if (s1_q) fb = sink_one_hr;
      if (s2_q && sink_two_hr < fb) fb = sink_two_hr;
      tgt = `BP_HR_BASE_MV + {2'h0, word[10:5]};
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         per_q <= 8'h0;
         ton_q <= 8'h0;
         cut_q <= 1'b0;
      end else begin
         per_q <= per_end ? 8'h0 : per_q + 8'h1;
         if (per_end) begin
            cut_q <= 1'b0;
            if (!active) ton_q <= 8'h0;
            else if (fb > tgt && ton_q < `BP_TON_MAX)
               ton_q <= ton_q + 8'h1;
            else if (fb < tgt && ton_q != 8'h0)
               ton_q <= ton_q - 8'h1;
         end else if (ocp_cmp) begin
            cut_q <= 1'b1;
         end
      end
   end
   // unlatched overvoltage holds the switch until the output drops
   always_ff @(posedge aclk) begin
      if (!aresetn) boost_gate <= 1'b0;
      else boost_gate <= active & ~ovp_cmp & ~cut_q & ~ocp_cmp &
                         ~per_end & (per_q < ton_q);
   end

   // current-limit density: windows of at least two events
   logic [13:0] win_q;
   logic [1:0]  ev_q;
   logic [3:0]  run_q;
   logic        ocp_ev;
   assign ocp_ev = ocp_cmp & ~ocp_prev_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         win_q      <= 14'h0;
         ev_q       <= 2'h0;
         run_q      <= 4'h0;
         ocp_prev_q <= 1'b0;
         ocp_set    <= 1'b0;
      end else begin
         ocp_prev_q <= ocp_cmp;
         ocp_set    <= 1'b0;
         if (win_q == `BP_WIN_CYC - 14'h1) begin
            win_q <= 14'h0;
            ev_q  <= {1'b0, ocp_ev};
            if (ev_q < `BP_OCP_MIN) begin
               run_q <= 4'h0;
            end else if (run_q == `BP_OCP_WINS - 4'h1) begin
               run_q   <= 4'h0;
               ocp_set <= 1'b1;
            end else begin
               run_q <= run_q + 4'h1;
            end
         end else begin
            win_q <= win_q + 14'h1;
            if (ocp_ev && ev_q != 2'h3) ev_q <= ev_q + 2'h1;
         end
      end
   end

   // overvoltage hits, latched shutdown after three with low headroom
   logic       ovp_prev_q, hr_low;
   logic [1:0] occ_q;
   assign hr_low = (s1_q && sink_one_hr < `BP_HR_LOW_MV) ||
                   (s2_q && sink_two_hr < `BP_HR_LOW_MV);
   assign ovp_set = ovp_cmp & ~ovp_prev_q;
   assign ovp_shut = ovp_set & latch_q & hr_low &
                     (occ_q == `BP_OVP_OCC - 2'h1);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ovp_prev_q <= 1'b0;
         occ_q      <= 2'h0;
      end else begin
         ovp_prev_q <= ovp_cmp;
         if (ovp_shut) occ_q <= 2'h0;
         else if (ovp_set && latch_q && hr_low)
            occ_q <= occ_q + 2'h1;
      end
   end

   // flags: a set in the clearing read's cycle survives it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ocp_flag_q <= 1'b0;
         ovp_flag_q <= 1'b0;
         lock_q     <= 1'b0;
      end else begin
         ocp_flag_q <= ocp_set | (ocp_flag_q & ~rd_clr);
         ovp_flag_q <= ovp_set | (ovp_flag_q & ~rd_clr);
         lock_q     <= ovp_shut | (lock_q & ~rd_clr);
      end
   end

   // registered driver controls
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         boost_switch_freq_select <= 1'b0;
         ovp_thresh_sel           <= 3'h0;
         sink_one_en              <= 1'b0;
         sink_two_en              <= 1'b0;
      end else begin
         boost_switch_freq_select <= smp_q[`BP_F_BFREQ];
         ovp_thresh_sel <= cfg_q[`BP_F_OVP_HI:`BP_F_OVP_LO];
         sink_one_en    <= backlight_enable_bit_q & s1_q;
         sink_two_en    <= backlight_enable_bit_q & s2_q;
      end
   end

   assign s_awready = awready_q;
   assign s_wready  = wready_q;
   assign s_bvalid  = bvalid_q;
   assign s_bresp   = bresp_q;
   assign s_arready = arready_q;
   assign s_rvalid  = rvalid_q;
   assign s_rresp   = rresp_q;
   assign s_rdata   = rdata_q;
endmodule // blpd_top

// File: dv/blpd_pwm_host.sv
// Purpose: far-side model of the host driving the pwm pin
// Assumes: widths given in aclk cycles by the bench
// Notes:   pin rests low while stopped, like an idle source
`timescale 1ns/10ps
module blpd_pwm_host (
   // clock and control
   input  wire logic        aclk,
   input  wire logic        run,
   input  wire logic [15:0] high_cyc,
   input  wire logic [15:0] low_cyc,
   // pin
   output logic             pwm_pin
);
   logic [15:0] cnt_q;
   // widths are never below 150 cycles, the 4 MHz minimum pulse
   // bench keeps periods of 5000 cycles, a 20 kHz input
   // full duty would need high held past the timeout
   always_ff @(posedge aclk) begin
      if (!run) begin
         pwm_pin <= 1'b0;
         cnt_q   <= 16'h0000;
      end else if (cnt_q >= (pwm_pin ? high_cyc : low_cyc) - 16'h0001) begin
         pwm_pin <= !pwm_pin;
         cnt_q   <= 16'h0000;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end
endmodule // blpd_pwm_host

// File: dv/blpd_assertions.sv
// Purpose: port-level checks of the pwm detect and fault slice
// Assumes: one clock domain, aresetn synchronous active low
// Notes:   bound to every blpd_top instance
`timescale 1ns/10ps
module blpd_assertions (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_arready,
   input wire logic        s_arvalid,
   input wire logic        s_rvalid,
   input wire logic        s_rready,
   input wire logic [31:0] s_rdata,
   input wire logic [1:0]  s_rresp,
   input wire logic        s_bvalid,
   input wire logic        s_bready,
   input wire logic [1:0]  s_bresp,
   input wire logic        ovp_cmp,
   input wire logic        ocp_cmp,
   input wire logic        boost_gate,
   input wire logic [19:0] current_code,
   input wire logic        sink_one_en,
   input wire logic        sink_two_en
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // answers stand until taken
   bvalid_hold_a: assert property (s_bvalid && !s_bready |=>
      s_bvalid && $stable(s_bresp)) else $error("write answer dropped");
   bvalid_drop_a: assert property (s_bvalid && s_bready |=> !s_bvalid)
      else $error("write answer repeated");
   rvalid_hold_a: assert property (s_rvalid && !s_rready |=>
      s_rvalid && $stable(s_rdata)) else $error("read answer dropped");
   read_answer_a: assert property (s_arvalid && s_arready |=> s_rvalid)
      else $error("read answer late");
   arready_busy_a: assert property (s_rvalid |-> !s_arready)
      else $error("read taken while answer pending");
   // switch off during overvoltage, cut on current limit; no current with sinks off
   ovp_gate_a: assert property (ovp_cmp && $past(ovp_cmp) |-> !boost_gate)
      else $error("switch on during overvoltage");
   ocp_gate_a: assert property ($rose(ocp_cmp) |-> ##[0:2] !boost_gate)
      else $error("switch not cut on current limit");
   code_idle_a: assert property ((!sink_one_en && !sink_two_en)[*4]
      |-> current_code == 20'h00000) else $error("current with sinks off");
   cover property (s_bvalid && s_bready);
   cover property (s_rvalid && s_rready && s_rresp == 2'h2);
   cover property ($fell(sink_one_en));
endmodule // blpd_assertions
bind blpd_top blpd_assertions u_chk (.*);

// File: dv/blpd_top_test.sv
// Purpose: self-checking bench of the pwm detect and fault slice
// Assumes: 4 MHz sampling for pwm work to keep the run short
// Notes:   timeout and ocp flag counts are too long to reach here
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
   $display("CHECK FAILED %0t got %0h exp %0h", $time, a, b); end end
module blpd_top_test;
   import blpd_pkg::*;
   logic        aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid;
   logic        s_rready, ovp_cmp, ocp_cmp, run;
   logic [7:0]  s_awaddr, s_araddr, sink_one_hr, sink_two_hr, v;
   logic [31:0] s_wdata, rdat;
   logic [15:0] hi_c, lo_c;
   logic [19:0] c_a, c_b;
   logic [1:0]  resp, s_bresp, s_rresp;
   wire         s_awready, s_wready, s_bvalid, s_arready, s_rvalid, pwm_pin;
   wire  [31:0] s_rdata;
   wire  [19:0] current_code;
   wire  [2:0]  ovp_thresh_sel;
   wire         boost_gate, boost_switch_freq_select, sink_one_en, sink_two_en;
   int          err_total, total_checks, seed, i;
   blpd_top DUT (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
      .s_wstrb(4'hf), .s_wvalid(s_wvalid), .s_wready(s_wready),
      .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
      .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
      .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
      .s_rready(s_rready), .pwm_pin(pwm_pin), .ovp_cmp(ovp_cmp),
      .ocp_cmp(ocp_cmp), .sink_one_hr(sink_one_hr), .sink_two_hr(sink_two_hr),
      .boost_gate(boost_gate), .boost_switch_freq_select(boost_switch_freq_select),
      .ovp_thresh_sel(ovp_thresh_sel), .current_code(current_code),
      .sink_one_en(sink_one_en), .sink_two_en(sink_two_en));
   blpd_pwm_host u_host (.aclk(aclk), .run(run), .high_cyc(hi_c),
      .low_cyc(lo_c), .pwm_pin(pwm_pin));
   // 100 MHz clock
   initial begin
      aclk = 1'b0;
      forever #5 aclk = !aclk;
   end
   // axi4-lite write: address and data offered together, bready held
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_awaddr <= a; s_wdata <= d; s_bready <= 1'b1;
      s_awvalid <= 1'b1; s_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
      end while (!s_bvalid);
      resp = s_bresp;
      s_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_arready) s_arvalid <= 1'b0;
      end while (!s_rvalid);
      rdat = s_rdata; resp = s_rresp;
      s_rready <= 1'b0;
   endtask
   // overvoltage hits of five cycles each
   task automatic ovp_hits(input int n);
      repeat (n) begin
         @(posedge aclk) ovp_cmp <= 1'b1;
         repeat (5) @(posedge aclk);
         ovp_cmp <= 1'b0;
         repeat (5) @(posedge aclk);
      end
   endtask
   task automatic stop_test;
      if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // watchdog sized about twice the longest expected run
   initial begin
      repeat (90000) @(posedge aclk);
      err_total++;
      stop_test;
   end
   initial begin
      {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
      {aresetn, ovp_cmp, ocp_cmp, run} = '0;
      {s_awaddr, s_araddr, s_wdata, hi_c, lo_c} = '0;
      sink_one_hr = 8'hc8; sink_two_hr = 8'hc8;
      seed = 20; err_total = 0; total_checks = 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h08); `CHK(rdat, 32'h0)
      rd(8'h40); `CHK(rdat, 32'h0)
      rd(8'h3c); `CHK(resp, 2'h2)
      wr(8'h3c, 32'hff); `CHK(resp, 2'h2)
      // random config fields, mirrored at the outputs
      for (i = 0; i < 4; i++) begin
         v = 8'($random(seed));
         wr(8'h08, {24'h0, v}); rd(8'h08); `CHK(rdat[7:0], v)
         `CHK(ovp_thresh_sel, v[7:5])
         wr(8'h0c, {24'h0, v}); rd(8'h0c); `CHK(rdat[7:0], v & 8'h87)
         `CHK(boost_switch_freq_select, v[7])
      end
      wr(8'h08, 32'h0); wr(8'h0c, 32'h04);
      // unlatched overvoltage flag, cleared by the read
      ovp_hits(1); rd(8'h40); `CHK(rdat[1], 1'b1)
      rd(8'h40); `CHK(rdat[1], 1'b0)
      // a few current-limit hits: too sparse for the flag
      repeat (3) begin
         @(posedge aclk) ocp_cmp <= 1'b1;
         repeat (4) @(posedge aclk);
         ocp_cmp <= 1'b0;
      end
      rd(8'h40); `CHK(rdat[0], 1'b0)
      // brightness commits only on the upper byte
      wr(8'h28, 32'h19); wr(8'h10, 32'h0); wr(8'h14, 32'h40);
      repeat (20) @(posedge aclk);
      c_a = current_code; `CHK(sink_one_en, 1'b1)
      wr(8'h10, 32'h7); repeat (20) @(posedge aclk);
      `CHK(current_code, c_a)
      wr(8'h14, 32'h40); repeat (20) @(posedge aclk);
      `CHK(current_code > c_a, 1'b1)
      c_a = current_code;
      wr(8'h08, 32'h10); repeat (20) @(posedge aclk);
      `CHK(current_code < c_a, 1'b1)
      // pwm duty 25 then 75 percent at 20 kHz, then inverted 25
      wr(8'h08, 32'h0); wr(8'h14, 32'hff); wr(8'h24, 32'h40);
      hi_c <= 16'd1250; lo_c <= 16'd3750; run <= 1'b1;
      repeat (15000) @(posedge aclk);
      c_a = current_code;
      hi_c <= 16'd3750; lo_c <= 16'd1250;
      repeat (15000) @(posedge aclk);
      c_b = current_code;
      `CHK(c_a < c_b, 1'b1)
      wr(8'h08, 32'h08); hi_c <= 16'd1250; lo_c <= 16'd3750;
      repeat (15000) @(posedge aclk);
      `CHK(current_code, c_b)
      // latched overvoltage with low headroom shuts down
      wr(8'h08, 32'h0); wr(8'h28, 32'h1b); sink_one_hr <= 8'h14;
      ovp_hits(3); repeat (5) @(posedge aclk);
      `CHK(sink_one_en, 1'b0)
      sink_one_hr <= 8'hc8;
      wr(8'h28, 32'h1b); rd(8'h28); `CHK(rdat[0], 1'b0)
      rd(8'h40); `CHK(rdat[1], 1'b1)
      wr(8'h28, 32'h1b); rd(8'h28); `CHK(rdat[0], 1'b1)
      stop_test;
   end
endmodule // blpd_top_test
